/* bgpc_top.sv */
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "bgpc_defs.svh"

module bgpc_top #(parameter int CNT_W = 16)
(
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        arst_n,
   // APB slave
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0]     prdata,
   output logic            pready,
   output logic            pslverr,
   // Pins and analog comparators
   input wire logic        ext_sync_in,
   input wire logic        fail_safe_mode,
   input wire logic [1:0]  peak_cmp,
   input wire logic [1:0]  ilim_cmp,
   input wire logic        comp_voltage_below_skip,
   input wire logic        comp_voltage_demand,
   input wire logic        boost_output_voltage_above_ov,
   input wire logic        boost_output_voltage_below_react,
   // Analog settings
   output logic [3:0]      phase_current_limit_sel,
   output logic [1:0]      skip_cycle_sel,
   output logic [6:0]      overvoltage_threshold,
   // Gate drive and interrupt
   output logic [1:0]      gate_drive,
   output logic            irq
);

   localparam int NSYNC = 10;

   if (CNT_W < 11 || CNT_W > 31)
   begin : g_bad_cnt_w
      $error("CNT_W cannot hold the longest internal period");
   end

   function automatic logic [CNT_W-1:0] sel_to_cyc(input logic [2:0] sel,
                                                   input int step);
      sel_to_cyc = CNT_W'(({29'h0, sel} + 32'h1) * 32'(step));
   endfunction : sel_to_cyc

   function automatic logic [CNT_W-1:0] fs_period(input logic [2:0] sel);
      int khz;
      case (sel)
         3'h0:    khz = `BGPC_FS_KHZ_0;
         3'h1:    khz = `BGPC_FS_KHZ_1;
         3'h2:    khz = `BGPC_FS_KHZ_2;
         3'h3:    khz = `BGPC_FS_KHZ_3;
         3'h4:    khz = `BGPC_FS_KHZ_4;
         3'h5:    khz = `BGPC_FS_KHZ_5;
         3'h6:    khz = `BGPC_FS_KHZ_6;
         default: khz = `BGPC_FS_KHZ_7;
      endcase
      fs_period = CNT_W'((`BGPC_SYS_CLK_MHZ * 1000) / khz);
   endfunction : fs_period

   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [NSYNC-1:0] meta_ff, sync_ff;
   wire  [NSYNC-1:0] async_in = {boost_output_voltage_below_react,
                                 boost_output_voltage_above_ov,
                                 comp_voltage_demand,
                                 comp_voltage_below_skip,
                                 ilim_cmp, peak_cmp,
                                 fail_safe_mode, ext_sync_in};

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

   wire       ext_s     = sync_ff[0];
   wire       fs_s      = sync_ff[1];
   wire [1:0] peak_s    = sync_ff[3:2];
   wire [1:0] ilim_s    = sync_ff[5:4];
   wire       skip_s    = sync_ff[6];
   wire       demand_s  = sync_ff[7];
   wire       ov_above  = sync_ff[8];
   wire       ov_react  = sync_ff[9];

   // ****************************************
   // Registers
   // ****************************************
   logic [31:0] ctrl_ff, cfg_ff, ovthr_ff, irq_stat_ff, irq_mask_ff;
   logic [31:0] prdata_ff, nxt_prdata;
   logic        ov_hold_ff, ov_flag_ff, fs_d_ff;
   logic [1:0]  gate_w, ilim_evt_w;

   wire acc_w   = psel & penable & pwrite;
   wire acc_r   = psel & penable & ~pwrite;
   wire hit_ctl = paddr == `BGPC_ADDR_CTRL;
   wire hit_cfg = paddr == `BGPC_ADDR_CFG;
   wire hit_ovt = paddr == `BGPC_ADDR_OVTHR;
   wire hit_sta = paddr == `BGPC_ADDR_STATUS;
   wire hit_ist = paddr == `BGPC_ADDR_IRQ_STAT;
   wire hit_imk = paddr == `BGPC_ADDR_IRQ_MASK;
   wire hit_any = hit_ctl | hit_cfg | hit_ovt | hit_sta | hit_ist | hit_imk;
   wire [31:0] status_w = {27'h0, ov_hold_ff, gate_w, fs_s, ov_flag_ff};
   wire [31:0] irq_evt  = {28'h0, fs_s & ~fs_d_ff, ilim_evt_w,
                           ov_above & ~ov_hold_ff};
   wire [31:0] irq_clr  = (acc_w && hit_ist) ?
                          (pwdata & `BGPC_IRQ_MASK_BITS) : 32'h0;

   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~hit_any;
   assign prdata  = prdata_ff;
   assign irq     = |(irq_stat_ff & irq_mask_ff);

   always_comb
   begin
      nxt_prdata = 32'h0;
      if (hit_ctl)
         nxt_prdata = ctrl_ff;
      else if (hit_cfg)
         nxt_prdata = cfg_ff;
      else if (hit_ovt)
         nxt_prdata = ovthr_ff;
      else if (hit_sta)
         nxt_prdata = status_w;
      else if (hit_ist)
         nxt_prdata = irq_stat_ff;
      else if (hit_imk)
         nxt_prdata = irq_mask_ff;
   end

   // Read data is captured in the setup cycle, so no wait state is needed
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
         prdata_ff <= 32'h0;
      else if (psel && !penable && !pwrite)
         prdata_ff <= nxt_prdata;
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ctrl_ff     <= `BGPC_CTRL_RST;
         cfg_ff      <= `BGPC_CFG_RST;
         ovthr_ff    <= `BGPC_OVTHR_RST;
         irq_mask_ff <= `BGPC_IRQ_RST;
      end
      else if (acc_w)
      begin
         if (hit_ctl)
            ctrl_ff <= pwdata & `BGPC_CTRL_MASK;
         if (hit_cfg)
            cfg_ff <= pwdata & `BGPC_CFG_MASK;
         if (hit_ovt)
            ovthr_ff <= pwdata & `BGPC_OVTHR_MASK;
         if (hit_imk)
            irq_mask_ff <= pwdata & `BGPC_IRQ_MASK_BITS;
      end
   end

   // Events win over a write-one-to-clear in the same cycle
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq_stat_ff <= `BGPC_IRQ_RST;
         fs_d_ff     <= 1'b0;
      end
      else
      begin
         irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_evt;
         fs_d_ff     <= fs_s;
      end
   end

   // ****************************************
   // Overvoltage protection
   // ****************************************
   wire rd_status = acc_r & hit_sta;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ov_hold_ff <= 1'b0;
         ov_flag_ff <= 1'b0;
      end
      else
      begin
         if (ov_above)
            ov_hold_ff <= 1'b1;
         else if (ov_react)
            ov_hold_ff <= 1'b0;
         if (ov_above)
            ov_flag_ff <= 1'b1;
         else if (rd_status && !ov_hold_ff)
            ov_flag_ff <= 1'b0;
      end
   end

   assign overvoltage_threshold = ovthr_ff[6:0];

   // ****************************************
   // Sync debounce and internal oscillator
   // ****************************************
   logic             ext_hist_ff, sync_deb_ff, int_sq_ff;
   logic [CNT_W-1:0] internal_osc_cnt_ff;
   wire  [CNT_W-1:0] fs_per = fs_period(cfg_ff[`BGPC_CFG_FSF_LSB +: 3]);
   wire              osc_wrap = internal_osc_cnt_ff >= fs_per - 1'b1;
   wire              osc_half = internal_osc_cnt_ff ==
                               (fs_per >> 1) - 1'b1;

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         ext_hist_ff <= 1'b0;
         sync_deb_ff <= 1'b0;
      end
      else
      begin
         ext_hist_ff <= ext_s;
         if (ext_hist_ff == ext_s)
            sync_deb_ff <= ext_s;
      end
   end

   // Oscillator stays parked outside fail-safe
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         internal_osc_cnt_ff <= '0;
         int_sq_ff           <= 1'b0;
      end
      else if (!fs_s)
      begin
         internal_osc_cnt_ff <= '0;
         int_sq_ff           <= 1'b0;
      end
      else
      begin
         internal_osc_cnt_ff <= osc_wrap ? '0 :
                                internal_osc_cnt_ff + 1'b1;
         if (osc_wrap || osc_half)
            int_sq_ff <= ~int_sq_ff;
      end
   end

   // Source swaps with no software action on fail-safe entry
   wire pwm_src = fs_s ? int_sq_ff : sync_deb_ff;

   // ****************************************
   // Phases
   // ****************************************
   wire skip_active = (ctrl_ff[`BGPC_CTRL_SKIP_LSB +: 2] != 2'b00) &
                      skip_s;
   wire block_all   = skip_active | ov_hold_ff | ov_above;
   wire [CNT_W-1:0] min_on_cyc  = sel_to_cyc(
                       cfg_ff[`BGPC_CFG_TON_LSB +: 3], `BGPC_TON_STEP_CYC);
   wire [CNT_W-1:0] min_off_cyc = sel_to_cyc(
                       cfg_ff[`BGPC_CFG_TOFF_LSB +: 3], `BGPC_TOFF_STEP_CYC);

   assign skip_cycle_sel          = ctrl_ff[`BGPC_CTRL_SKIP_LSB +: 2];
   assign phase_current_limit_sel = cfg_ff[`BGPC_CFG_ILIM_LSB +: 4];
   assign gate_drive              = gate_w;

   for (genvar g = 0; g < 2; g++)
   begin : g_phase
      bgpc_phase_if #(.CNT_W(CNT_W)) ph_if ();

      assign ph_if.src_level   = pwm_src;
      assign ph_if.enable      = ctrl_ff[`BGPC_CTRL_EN_LSB + g];
      assign ph_if.edge_inv    = ctrl_ff[`BGPC_CTRL_INV_LSB + g];
      assign ph_if.block       = block_all;
      assign ph_if.demand      = demand_s;
      assign ph_if.peak_cmp    = peak_s[g];
      assign ph_if.ilim_trip   = ilim_s[g];
      assign ph_if.min_on_cyc  = min_on_cyc;
      assign ph_if.min_off_cyc = min_off_cyc;
      assign gate_w[g]         = ph_if.gate;
      assign ilim_evt_w[g]     = ph_if.ilim_evt;

      bgpc_phase #(.CNT_W(CNT_W)) u_phase
      (
         .sys_clk (sys_clk),
         .arst_n  (arst_n),
         .ph      (ph_if.phase)
      );
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_sync_debounce: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      $changed(sync_deb_ff) |-> ($past(ext_s, 1) == sync_deb_ff &&
                                  $past(ext_s, 2) == sync_deb_ff))
      else $error("sync edge accepted without two stable samples");

   chk_ilim_cut: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      ilim_s[0] |=> !gate_w[0])
      else $error("phase 0 gate stayed on through current limit");

   chk_ov_gate_off: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      ov_hold_ff |=> gate_w == 2'b00)
      else $error("gate on during overvoltage hold");

   chk_ov_flag_held: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      ov_hold_ff |-> ov_flag_ff)
      else $error("overvoltage flag cleared while still held");

   chk_phase_disable: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !ctrl_ff[`BGPC_CTRL_EN_LSB + 1] |=> !gate_w[1])
      else $error("disabled phase 1 drove its gate");

   chk_skip_stop: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      skip_active |=> gate_w == 2'b00)
      else $error("gate pulsed while skipping cycles");

   chk_osc_parked: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      !fs_s ##1 !fs_s |-> internal_osc_cnt_ff == '0 && !int_sq_ff)
      else $error("internal oscillator ran in normal mode");

   cov_failsafe_pulse: cover property (
      @(posedge sys_clk) disable iff (!arst_n)
      fs_s && $rose(gate_w[0]));

   cov_ilim_trip: cover property (
      @(posedge sys_clk) disable iff (!arst_n)
      ilim_evt_w[0] ##1 !gate_w[0]);

   cov_ov_recover: cover property (
      @(posedge sys_clk) disable iff (!arst_n)
      $fell(ov_hold_ff) ##[1:500] $rose(gate_w[0]));

endmodule : bgpc_top

/* bgpc_defs.svh */
`ifndef BGPC_DEFS_SVH
`define BGPC_DEFS_SVH

// ****************************************
// Timing
// ****************************************
`define BGPC_SYS_CLK_MHZ    200
`define BGPC_TON_STEP_NS    50
`define BGPC_TON_STEP_CYC   ((`BGPC_TON_STEP_NS*`BGPC_SYS_CLK_MHZ+999)/1000)
`define BGPC_TOFF_STEP_NS   100
`define BGPC_TOFF_STEP_CYC  ((`BGPC_TOFF_STEP_NS*`BGPC_SYS_CLK_MHZ+999)/1000)
`define BGPC_FS_KHZ_0       200
`define BGPC_FS_KHZ_1       300
`define BGPC_FS_KHZ_2       400
`define BGPC_FS_KHZ_3       500
`define BGPC_FS_KHZ_4       600
`define BGPC_FS_KHZ_5       700
`define BGPC_FS_KHZ_6       800
`define BGPC_FS_KHZ_7       1000

// ****************************************
// Register offsets
// ****************************************
`define BGPC_ADDR_CTRL      8'h00
`define BGPC_ADDR_CFG       8'h04
`define BGPC_ADDR_OVTHR     8'h08
`define BGPC_ADDR_STATUS    8'h0C
`define BGPC_ADDR_IRQ_STAT  8'h10
`define BGPC_ADDR_IRQ_MASK  8'h14

// ****************************************
// Fields and reset values
// ****************************************
`define BGPC_CTRL_EN_LSB    0
`define BGPC_CTRL_INV_LSB   2
`define BGPC_CTRL_SKIP_LSB  4
`define BGPC_CTRL_MASK      32'h0000_003F
`define BGPC_CFG_ILIM_LSB   0
`define BGPC_CFG_TON_LSB    4
`define BGPC_CFG_TOFF_LSB   8
`define BGPC_CFG_FSF_LSB    12
`define BGPC_CFG_MASK       32'h0000_777F
`define BGPC_OVTHR_MASK     32'h0000_007F
`define BGPC_IRQ_MASK_BITS  32'h0000_000F
`define BGPC_CTRL_RST       32'h0000_0000
`define BGPC_CFG_RST        32'h0000_0000
`define BGPC_OVTHR_RST      32'h0000_0000
`define BGPC_IRQ_RST        32'h0000_0000

`endif

/* bgpc_pkg.sv */
package bgpc_pkg;

   typedef enum logic [1:0]
   {
      PH_IDLE = 2'b00,
      PH_ON   = 2'b01,
      PH_OFF  = 2'b10
   } bgpc_ph_state_type;

endpackage : bgpc_pkg

/* bgpc_phase_if.sv */
`timescale 1ns/1ps

interface bgpc_phase_if #(parameter int CNT_W = 16);
   logic             src_level;
   logic             enable;
   logic             edge_inv;
   logic             block;
   logic             demand;
   logic             peak_cmp;
   logic             ilim_trip;
   logic [CNT_W-1:0] min_on_cyc;
   logic [CNT_W-1:0] min_off_cyc;
   logic             gate;
   logic             ilim_evt;

   modport phase (input src_level, enable, edge_inv, block, demand,
                  peak_cmp, ilim_trip, min_on_cyc, min_off_cyc,
                  output gate, ilim_evt);
   modport ctrl (output src_level, enable, edge_inv, block, demand,
                 peak_cmp, ilim_trip, min_on_cyc, min_off_cyc,
                 input gate, ilim_evt);
endinterface : bgpc_phase_if

/* bgpc_phase.sv */
`timescale 1ns/1ps

module bgpc_phase #(parameter int CNT_W = 16)
(
   // Clock and reset
   input wire logic     sys_clk,
   input wire logic     arst_n,
   // Control side
   bgpc_phase_if.phase  ph
);

   bgpc_pkg::bgpc_ph_state_type state_ff, nxt_state;
   logic [CNT_W-1:0]            per_cnt_ff, period_ff, tcnt_ff, nxt_tcnt;
   logic                        lvl_d_ff, gate_ff;
   wire                         lvl = ph.src_level ^ ph.edge_inv;
   wire                         start_edge = lvl & ~lvl_d_ff;
   wire [CNT_W-1:0]             max_on = (period_ff > ph.min_off_cyc) ?
                                   period_ff - ph.min_off_cyc : '0;
   wire                         pulse_ok = ph.enable & ~ph.block &
                                   ph.demand & ~ph.ilim_trip & (max_on != '0);
   wire                         stop_hard = ~ph.enable | ph.block |
                                   ph.ilim_trip;
   wire                         stop_soft = (ph.peak_cmp &&
                                   tcnt_ff >= ph.min_on_cyc) ||
                                   tcnt_ff >= max_on;

   assign ph.gate     = gate_ff;
   assign ph.ilim_evt = (state_ff == bgpc_pkg::PH_ON) & ph.ilim_trip;

   // ****************************************
   // Period measurement
   // ****************************************
   // Unknown period reads zero, so the first cycle after reset is dropped
   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         lvl_d_ff   <= 1'b0;
         per_cnt_ff <= '0;
         period_ff  <= '0;
      end
      else
      begin
         lvl_d_ff <= lvl;
         if (start_edge)
         begin
            per_cnt_ff <= {{(CNT_W-1){1'b0}}, 1'b1};
            period_ff  <= per_cnt_ff;
         end
         else if (per_cnt_ff != '1)
            per_cnt_ff <= per_cnt_ff + 1'b1;
      end
   end

   // ****************************************
   // Gate sequencer
   // ****************************************
   always_comb
   begin
      nxt_state = state_ff;
      nxt_tcnt  = tcnt_ff + 1'b1;
      case (state_ff)
         bgpc_pkg::PH_IDLE:
         begin
            nxt_tcnt = '0;
            if (start_edge && pulse_ok)
            begin
               nxt_state = bgpc_pkg::PH_ON;
               nxt_tcnt  = {{(CNT_W-1){1'b0}}, 1'b1};
            end
         end
         bgpc_pkg::PH_ON:
            if (stop_hard || stop_soft)
            begin
               nxt_state = bgpc_pkg::PH_OFF;
               nxt_tcnt  = {{(CNT_W-1){1'b0}}, 1'b1};
            end
         bgpc_pkg::PH_OFF:
            if (tcnt_ff >= ph.min_off_cyc)
               nxt_state = bgpc_pkg::PH_IDLE;
         default:
            nxt_state = bgpc_pkg::PH_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state_ff <= bgpc_pkg::PH_IDLE;
         tcnt_ff  <= '0;
         gate_ff  <= 1'b0;
      end
      else
      begin
         state_ff <= nxt_state;
         tcnt_ff  <= nxt_tcnt;
         gate_ff  <= (nxt_state == bgpc_pkg::PH_ON);
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   chk_min_on_hold: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (state_ff == bgpc_pkg::PH_ON && !stop_hard &&
       tcnt_ff < ph.min_on_cyc && tcnt_ff < max_on)
      |=> state_ff == bgpc_pkg::PH_ON)
      else $error("gate dropped before minimum on-time");

   chk_max_duty_cap: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      state_ff == bgpc_pkg::PH_ON |-> tcnt_ff <= max_on)
      else $error("on-time ran past maximum duty point");

   chk_no_demand_idle: assert property (
      @(posedge sys_clk) disable iff (!arst_n)
      (state_ff == bgpc_pkg::PH_IDLE && start_edge && !ph.demand)
      |=> !gate_ff)
      else $error("pulse started with no duty demand");

endmodule : bgpc_phase

/* bgpc_sync_model.sv */
`timescale 1ns/1ps

// ****************************************
// Sync clock source standing in for the controller
// ****************************************
module bgpc_sync_model #(parameter int HALF = 200)
(
   // Clock and control
   input wire logic sys_clk,
   input wire logic run,
   // Sync pin
   output logic     ext_sync_in
);
   int cnt_ff = 0;

   initial ext_sync_in = 1'b0;

   // Stopped source stands still at its last level
   always @(posedge sys_clk)
   begin
      if (run)
      begin
         cnt_ff <= (cnt_ff == HALF - 1) ? 0 : cnt_ff + 1;
         if (cnt_ff == HALF - 1)
            ext_sync_in <= ~ext_sync_in;
      end
   end
endmodule : bgpc_sync_model

/* bgpc_top_tb_top.sv */
`timescale 1ns/1ps
`include "bgpc_defs.svh"

module bgpc_top_tb_top;
   logic sys_clk, arst_n, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic ext_sync_in, fsm, demand, skip_low, ov_hi, react, run, err_q;
   logic [1:0] peak, ilim, skip_cycle_sel, gate_drive, gprev;
   logic [3:0] phase_current_limit_sel;
   logic [6:0] overvoltage_threshold;
   int errors, num_checks, cyc, rises[2], wid[2], lastw[2], rt[2];

   bgpc_top #(.CNT_W(16)) dut
   (
      .sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_sync_in(ext_sync_in),
      .fail_safe_mode(fsm), .peak_cmp(peak), .ilim_cmp(ilim),
      .comp_voltage_below_skip(skip_low), .comp_voltage_demand(demand),
      .boost_output_voltage_above_ov(ov_hi),
      .boost_output_voltage_below_react(react),
      .phase_current_limit_sel(phase_current_limit_sel),
      .skip_cycle_sel(skip_cycle_sel),
      .overvoltage_threshold(overvoltage_threshold),
      .gate_drive(gate_drive), .irq(irq)
   );

   // 500 kHz sync, inside the 1 MHz ceiling
   bgpc_sync_model #(.HALF(200)) sync_src
   (
      .sys_clk(sys_clk), .run(run), .ext_sync_in(ext_sync_in)
   );

   // ****************************************
   // Clock, gate monitor and timeout
   // ****************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   // Sampled mid-cycle, away from the bench's own edge
   always @(negedge sys_clk)
   begin
      cyc++;
      for (int i = 0; i < 2; i++)
      begin
         if (gate_drive[i] === 1'b1 && gprev[i] !== 1'b1)
         begin
            rises[i]++;
            rt[i] = cyc;
            wid[i] = 0;
         end
         if (gate_drive[i] === 1'b1)
            wid[i]++;
         else if (gprev[i] === 1'b1)
            lastw[i] = wid[i];
      end
      gprev = gate_drive;
      if (cyc > 60000)
      begin
         errors++;
         wrap_up();
      end
   end

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      @(posedge sys_clk);
      while (pready !== 1'b1)
      begin
         @(posedge sys_clk);
      end
      q = prdata;
      err_q = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   task automatic setc(input logic [31:0] c, input logic [31:0] f);
      apb(1'b1, `BGPC_ADDR_CTRL, c);
      apb(1'b1, `BGPC_ADDR_CFG, f);
   endtask : setc

   // First 800 cycles after a change are left out of the count
   task automatic watch(input int n);
      repeat (800) @(posedge sys_clk);
      rises = '{0, 0};
      repeat (n) @(posedge sys_clk);
   endtask : watch

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_regs();
      apb(1'b0, `BGPC_ADDR_CTRL, 32'h0);
      chk(q, `BGPC_CTRL_RST);
      apb(1'b1, `BGPC_ADDR_CTRL, 32'h0000_0035);
      apb(1'b0, `BGPC_ADDR_CTRL, 32'h0);
      chk(q, 32'h0000_0035);
      chk(32'(skip_cycle_sel), 32'h3);
      apb(1'b1, `BGPC_ADDR_CFG, 32'hFFFF_FFFF);
      apb(1'b0, `BGPC_ADDR_CFG, 32'h0);
      chk(q, `BGPC_CFG_MASK);
      chk(32'(phase_current_limit_sel), 32'hF);
      apb(1'b1, `BGPC_ADDR_OVTHR, 32'hFFFF_FFFF);
      chk(32'(overvoltage_threshold), 32'h7F);
      apb(1'b0, 8'h20, 32'h0);
      chk({q[30:0], err_q}, 32'h1);
      chk(32'(pready), 32'h1);
   endtask : t_regs

   task automatic t_on_time();
      int mn;
      demand <= 1'b1;
      peak <= 2'b11;
      for (int s = 0; s < 8; s += 7)
      begin
         setc(32'h1, 32'(s) << 4);
         watch(1600);
         mn = (s + 1) * `BGPC_TON_STEP_CYC;
         chk(32'(rises[0] >= 3), 32'h1);
         chk(32'(rises[1]), 32'h0);
         chk(32'(lastw[0] >= mn && lastw[0] <= mn + 3), 32'h1);
      end
   endtask : t_on_time

   task automatic t_max_duty();
      int mx;
      peak <= 2'b00;
      setc(32'h1, 32'h0000_0200);
      watch(1200);
      mx = 400 - 3 * `BGPC_TOFF_STEP_CYC;
      chk(32'(lastw[0] <= mx + 1 && lastw[0] >= mx - 6), 32'h1);
   endtask : t_max_duty

   task automatic t_ilim();
      int n;
      setc(32'h1, 32'h0000_0070);
      apb(1'b1, `BGPC_ADDR_IRQ_MASK, 32'h0);
      apb(1'b1, `BGPC_ADDR_IRQ_STAT, 32'hF);
      n = 0;
      while (gate_drive[0] !== 1'b1 && n < 900)
      begin
         @(posedge sys_clk);
         n++;
      end
      repeat (5) @(posedge sys_clk);
      chk(32'(gate_drive[0]), 32'h1);
      ilim <= 2'b01;
      n = 0;
      while (gate_drive[0] === 1'b1 && n < 20)
      begin
         @(posedge sys_clk);
         n++;
      end
      ilim <= 2'b00;
      // Trip lands well inside the 80-cycle minimum on-time
      chk(32'(n <= 5), 32'h1);
      apb(1'b0, `BGPC_ADDR_IRQ_STAT, 32'h0);
      chk(q & 32'h2, 32'h2);
      chk(32'(irq), 32'h0);
      apb(1'b1, `BGPC_ADDR_IRQ_MASK, 32'h2);
      chk(32'(irq), 32'h1);
      apb(1'b1, `BGPC_ADDR_IRQ_STAT, 32'h2);
      chk(32'(irq), 32'h0);
      apb(1'b1, `BGPC_ADDR_IRQ_MASK, 32'h0);
   endtask : t_ilim

   task automatic t_block();
      peak <= 2'b11;
      demand <= 1'b0;
      setc(32'h1, 32'h0);
      watch(800);
      chk(32'(rises[0]), 32'h0);
      demand <= 1'b1;
      skip_low <= 1'b1;
      for (int k = 1; k < 4; k++)
      begin
         setc(32'h1 | 32'(k << 4), 32'h0);
         watch(800);
         chk(32'(rises[0]), 32'h0);
      end
      setc(32'h1, 32'h0);
      watch(800);
      chk(32'(rises[0] > 0), 32'h1);
      skip_low <= 1'b0;
      ov_hi <= 1'b1;
      react <= 1'b0;
      watch(800);
      chk(32'(rises[0]), 32'h0);
      // Between the two thresholds the flag must survive a read
      ov_hi <= 1'b0;
      apb(1'b0, `BGPC_ADDR_STATUS, 32'h0);
      apb(1'b0, `BGPC_ADDR_STATUS, 32'h0);
      chk(32'(q[0]), 32'h1);
      react <= 1'b1;
      repeat (4) @(posedge sys_clk);
      apb(1'b0, `BGPC_ADDR_STATUS, 32'h0);
      chk(32'(q[0]), 32'h1);
      apb(1'b0, `BGPC_ADDR_STATUS, 32'h0);
      chk(32'(q[0]), 32'h0);
      watch(800);
      chk(32'(rises[0] > 0), 32'h1);
   endtask : t_block

   task automatic t_failsafe();
      int e;
      run <= 1'b0;
      watch(1200);
      chk(32'(rises[0]), 32'h0);
      fsm <= 1'b1;
      for (int s = 0; s < 8; s += 7)
      begin
         setc(32'h1, 32'(s) << 12);
         watch(2000);
         e = (s == 0 ? `BGPC_FS_KHZ_0 : `BGPC_FS_KHZ_7) / 100;
         chk(32'(rises[0] >= e - 1 && rises[0] <= e + 1), 32'h1);
      end
      apb(1'b0, `BGPC_ADDR_IRQ_STAT, 32'h0);
      chk(q & 32'h8, 32'h8);
      fsm <= 1'b0;
      run <= 1'b1;
   endtask : t_failsafe

   task automatic t_invert();
      int d;
      setc(32'h0000_000B, 32'h0);
      watch(1200);
      d = (rt[1] - rt[0] + 800) % 400;
      chk(32'(d >= 195 && d <= 205), 32'h1);
      chk(32'(rises[1] > 0), 32'h1);
   endtask : t_invert

   task automatic wrap_up();
      if (errors == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : wrap_up

   initial
   begin
      {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
      {fsm, demand, skip_low, ov_hi, peak, ilim} = '0;
      react = 1'b1;
      run = 1'b1;
      repeat (16) @(posedge sys_clk);
      arst_n <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_on_time();
      t_max_duty();
      t_ilim();
      t_block();
      t_failsafe();
      t_invert();
      wrap_up();
   end
endmodule : bgpc_top_tb_top
